// >>> src/rlds_map.svh
// Register offsets, field positions, reset values and clock and line rates
`ifndef RLDS_MAP_SVH
`define RLDS_MAP_SVH

// Register offsets, one byte register per port above each base
`define RLDS_CFG_BASE    8'h00
`define RLDS_STAT_BASE   8'h10
`define RLDS_CNT_BASE    8'h20

// Configuration field positions
`define RLDS_CFG_SEL_BIT 0
`define RLDS_CFG_RC_LSB  1
`define RLDS_CFG_POL_BIT 3
`define RLDS_CFG_T1_BIT  4
`define RLDS_CFG_RST     5'h00

// Receive code field values
`define RLDS_RC_NRZ      2'h0
`define RLDS_RC_CMI      2'h1
`define RLDS_RC_AMI      2'h2
`define RLDS_RC_ZCS      2'h3

// Timing: system clock and line rates in kHz and kbit/s
`define RLDS_CLK_KHZ     20000
`define RLDS_E1_KBPS     2048
`define RLDS_T1_KBPS     1544

`endif

// >>> src/rlds_pkg.sv
// Types shared by the receive line input select block
`include "rlds_map.svh"
package rlds_pkg;

  typedef enum logic [1:0] {
    RLDS_SRC_ANALOG  = 2'h0,
    RLDS_SRC_DUAL    = 2'h1,
    RLDS_SRC_OPT_CMI = 2'h3,
    RLDS_SRC_OPT_EXT = 2'h2
  } rlds_mode_t;

  typedef struct packed {
    logic       line_t1;
    logic       rx_input_polarity;
    logic [1:0] rx_code_field;
    logic       digital_line_select;
  } rlds_cfg_t;

  typedef struct packed {
    logic ana_a;
    logic ana_b;
    logic rail_p;
    logic rail_n;
    logic opt;
  } rlds_pins_t;

  typedef struct packed {
    logic [4:0] ph;
    logic       smp_p;
    logic       smp_n;
    logic       smp_lvl;
    logic       prev_lvl;
    logic       prev_pulse;
    logic       last_pos;
    logic [7:0] hist;
    logic [7:0] vf;
    logic [3:0] ser;
    logic [2:0] ser_cnt;
    logic       data;
    logic       valid;
    logic [7:0] cnt;
  } rlds_port_st_t;

endpackage

// >>> src/rlds_link_cap.sv
// Optical clock domain capture and word crossing into system clock
`timescale 1ns/1ps
`default_nettype none
module rlds_link_cap #(
  parameter int unsigned WORD_W = 4
) (
  // Link side
  input  wire logic              link_clk,
  input  wire logic              link_data,
  // System side
  input  wire logic              clk,
  input  wire logic              rst_b,
  output logic [WORD_W-1:0]      word,
  output logic                   word_stb
);

  localparam int unsigned CW = $clog2(WORD_W);

  if (WORD_W < 2 || WORD_W > 8) begin : g_chk
    $error("rlds_link_cap: WORD_W must be 2..8");
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: shift in bits, publish a word with a toggle
  logic [WORD_W-1:0] sh_q, sh_d, lw_q, lw_d;
  logic [CW-1:0]     lc_q, lc_d;
  logic              tog_q, tog_d;

  always_comb begin
    sh_d  = {sh_q[WORD_W-2:0], link_data};
    lc_d  = lc_q + CW'(1);
    lw_d  = lw_q;
    tog_d = tog_q;
    if (lc_q == CW'(WORD_W - 1)) begin
      lc_d  = '0;
      lw_d  = sh_d;
      tog_d = ~tog_q;
    end
  end

  always_ff @(negedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q  <= '0;
      lc_q  <= '0;
      lw_q  <= '0;
      tog_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      lc_q  <= lc_d;
      lw_q  <= lw_d;
      tog_q <= tog_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System domain: synchronise toggle, take the stable word
  logic [2:0]        ts_q, ts_d;
  logic [WORD_W-1:0] w_q, w_d;
  logic              s_q, s_d;

  always_comb begin
    ts_d = {ts_q[1:0], tog_q};
    s_d  = ts_q[2] ^ ts_q[1];
    w_d  = s_d ? lw_q : w_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_q <= '0;
      s_q  <= 1'b0;
      w_q  <= '0;
    end else begin
      ts_q <= ts_d;
      s_q  <= s_d;
      w_q  <= w_d;
    end
  end

  assign word     = w_q;
  assign word_stb = s_q;

endmodule // rlds_link_cap
`default_nettype wire

// >>> src/rlds_top.sv
// Four-port receive input select, clock recovery and line decoding
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rlds_map.svh"
module rlds_top #(
  parameter int unsigned N_PORTS = 4,
  parameter int unsigned WORD_W  = 4
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  // Sliced analog receiver pair
  input  wire logic [N_PORTS-1:0] rx_analog_line_a,
  input  wire logic [N_PORTS-1:0] rx_analog_line_b,
  // Digital receive pins
  input  wire logic [N_PORTS-1:0] rx_positive_rail_in,
  input  wire logic [N_PORTS-1:0] rx_negative_rail_in,
  input  wire logic [N_PORTS-1:0] rx_optical_data_in,
  input  wire logic [N_PORTS-1:0] rx_optical_clock_in,
  // Decoded receive stream
  output logic [N_PORTS-1:0]      rx_data,
  output logic [N_PORTS-1:0]      rx_valid
);
  import rlds_pkg::*;

  localparam int PER_E1_I = (`RLDS_CLK_KHZ + `RLDS_E1_KBPS / 2)
                            / `RLDS_E1_KBPS;
  localparam int PER_T1_I = (`RLDS_CLK_KHZ + `RLDS_T1_KBPS / 2)
                            / `RLDS_T1_KBPS;
  localparam logic [4:0] PER_E1 = 5'(PER_E1_I);
  localparam logic [4:0] PER_T1 = 5'(PER_T1_I);
  localparam logic [4:0] QTR_E1 = 5'(PER_E1_I / 4);
  localparam logic [4:0] QTR_T1 = 5'(PER_T1_I / 4);
  localparam logic [4:0] TQ_E1  = 5'((PER_E1_I * 3) / 4);
  localparam logic [4:0] TQ_T1  = 5'((PER_T1_I * 3) / 4);

  if (N_PORTS < 1 || N_PORTS > 4) begin : g_chk_ports
    $error("rlds_top: N_PORTS must be 1..4");
  end
  if (PER_E1_I < 4 || PER_T1_I > 31) begin : g_chk_per
    $error("rlds_top: clock to line rate ratio out of range");
  end
  if (WORD_W != 4) begin : g_chk_word
    $error("rlds_top: serializer serves WORD_W of 4 only");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic rlds_mode_t rlds_mode(input rlds_cfg_t c);
    rlds_mode_t m;
    m = RLDS_SRC_OPT_EXT;
    if (!c.digital_line_select)
      m = RLDS_SRC_ANALOG;
    else if (c.rx_code_field[1])
      m = RLDS_SRC_DUAL;
    else if (c.rx_code_field == `RLDS_RC_CMI)
      m = RLDS_SRC_OPT_CMI;
    return m;
  endfunction

  function automatic logic rlds_hit(input logic [7:0] a,
                                    input logic [7:0] base);
    return (a >= base) && (a < base + 8'(N_PORTS));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file
  rlds_cfg_t  cfg_q [N_PORTS];
  rlds_cfg_t  cfg_d [N_PORTS];
  logic [7:0] rd_q, rd_d;
  logic [1:0] idx;
  logic [N_PORTS-1:0] dat_w;
  logic [N_PORTS-1:0] val_w;
  logic [N_PORTS-1:0] last_w;
  logic [1:0]         mode_w [N_PORTS];
  logic [7:0]         cnt_w  [N_PORTS];

  always_comb begin
    cfg_d = cfg_q;
    rd_d  = 8'h00;
    idx   = reg_addr[1:0];
    if (reg_wr && rlds_hit(reg_addr, `RLDS_CFG_BASE)) begin
      cfg_d[idx].digital_line_select = reg_wdata[`RLDS_CFG_SEL_BIT];
      cfg_d[idx].rx_code_field =
        reg_wdata[`RLDS_CFG_RC_LSB +: 2];
      cfg_d[idx].rx_input_polarity = reg_wdata[`RLDS_CFG_POL_BIT];
      cfg_d[idx].line_t1 = reg_wdata[`RLDS_CFG_T1_BIT];
    end
    if (reg_rd) begin
      if (rlds_hit(reg_addr, `RLDS_CFG_BASE)) begin
        rd_d[`RLDS_CFG_SEL_BIT] = cfg_q[idx].digital_line_select;
        rd_d[`RLDS_CFG_RC_LSB +: 2] = cfg_q[idx].rx_code_field;
        rd_d[`RLDS_CFG_POL_BIT] = cfg_q[idx].rx_input_polarity;
        rd_d[`RLDS_CFG_T1_BIT] = cfg_q[idx].line_t1;
      end else if (rlds_hit(reg_addr, `RLDS_STAT_BASE)) begin
        rd_d[1:0] = mode_w[idx];
        rd_d[2]   = last_w[idx];
      end else if (rlds_hit(reg_addr, `RLDS_CNT_BASE)) begin
        rd_d = cnt_w[idx];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < N_PORTS; k++) begin
        cfg_q[k] <= rlds_cfg_t'(`RLDS_CFG_RST);
      end
      rd_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      rd_q  <= rd_d;
    end
  end

  assign reg_rdata = rd_q;
  assign rx_data   = dat_w;
  assign rx_valid  = val_w;

  ////////////////////////////////////////////////////////////////////////
  // Per-port receive path
  // Independent port state
  for (genvar i = 0; i < N_PORTS; i++) begin : g_port
    rlds_pins_t    s1_q, s2_q, pin;
    rlds_port_st_t st_q, st_d;
    rlds_mode_t    mode;
    logic [WORD_W-1:0] word;
    logic          word_stb;
    logic          lo, pp, pn, lvl, pulse, resync, emit, bit_v, viol;
    logic          t1, zcs;
    logic [4:0]    per, qtr, tq;

    assign pin = '{ana_a:  rx_analog_line_a[i],
                   ana_b:  rx_analog_line_b[i],
                   rail_p: rx_positive_rail_in[i],
                   rail_n: rx_negative_rail_in[i],
                   opt:    rx_optical_data_in[i]};

    rlds_link_cap #(
      .WORD_W (WORD_W)
    ) u_cap (
      .link_clk  (rx_optical_clock_in[i]),
      .link_data (rx_optical_data_in[i]),
      .clk       (clk),
      .rst_b     (rst_b),
      .word      (word),
      .word_stb  (word_stb)
    );

    always_comb begin
      st_d       = st_q;
      st_d.valid = 1'b0;
      mode       = rlds_mode(cfg_q[i]);
      t1         = cfg_q[i].line_t1;
      lo         = ~cfg_q[i].rx_input_polarity;
      if (mode == RLDS_SRC_ANALOG) begin
        pp = s2_q.ana_a;
        pn = s2_q.ana_b;
      end else begin
        pp = s2_q.rail_p ^ lo;
        pn = s2_q.rail_n ^ lo;
      end
      lvl   = s2_q.opt ^ lo;
      pulse = pp | pn;
      per   = t1 ? PER_T1 : PER_E1;
      qtr   = t1 ? QTR_T1 : QTR_E1;
      tq    = t1 ? TQ_T1 : TQ_E1;
      zcs   = cfg_q[i].rx_code_field == `RLDS_RC_ZCS;
      // DPLL realigns on pulse leading edge, or on a falling level edge in CMI mode
      if (mode == RLDS_SRC_OPT_CMI)
        resync = st_q.prev_lvl & ~lvl;
      else
        resync = pulse & ~st_q.prev_pulse;
      st_d.prev_lvl   = lvl;
      st_d.prev_pulse = pulse;
      if (resync)
        st_d.ph = 5'h01;
      else if (st_q.ph >= per - 5'h01)
        st_d.ph = 5'h00;
      else
        st_d.ph = st_q.ph + 5'h01;
      // Sample rails at recovered quarter bit
      if (st_q.ph == qtr) begin
        st_d.smp_p   = pp;
        st_d.smp_n   = pn;
        st_d.smp_lvl = lvl;
      end
      emit  = (st_q.ph == tq) && (mode != RLDS_SRC_OPT_EXT);
      bit_v = 1'b0;
      viol  = 1'b0;
      if (emit) begin
        if (mode == RLDS_SRC_OPT_CMI) begin
          bit_v = st_q.smp_lvl == lvl;
        end else begin
          bit_v = st_q.smp_p | st_q.smp_n;
          viol  = bit_v && (st_q.smp_p == st_q.last_pos);
          if (bit_v)
            st_d.last_pos = st_q.smp_p;
        end
        st_d.hist = {st_q.hist[6:0], bit_v};
        st_d.vf   = {st_q.vf[6:0], viol};
        if (zcs && mode != RLDS_SRC_OPT_CMI) begin
          if (t1 && st_d.vf[1] && st_d.vf[4])
            st_d.hist = 8'h00;
          else if (!t1 && st_d.vf[0])
            st_d.hist[3:0] = 4'h0;
          st_d.data = st_q.hist[7];
        end else begin
          st_d.data = bit_v;
        end
        st_d.valid = 1'b1;
      end
      if (word_stb) begin
        st_d.ser     = word;
        st_d.ser_cnt = 3'(WORD_W);
      end else if (st_q.ser_cnt != 3'h0) begin
        st_d.ser     = {st_q.ser[2:0], 1'b0};
        st_d.ser_cnt = st_q.ser_cnt - 3'h1;
        if (mode == RLDS_SRC_OPT_EXT) begin
          st_d.data  = st_q.ser[3] ^ lo;
          st_d.valid = 1'b1;
        end
      end
      if (st_d.valid)
        st_d.cnt = st_q.cnt + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_q <= '0;
        s2_q <= '0;
        st_q <= '0;
      end else begin
        s1_q <= pin;
        s2_q <= s1_q;
        st_q <= st_d;
      end
    end

    assign dat_w[i]  = st_q.data;
    assign val_w[i]  = st_q.valid;
    assign last_w[i] = st_q.data;
    assign mode_w[i] = mode;
    assign cnt_w[i]  = st_q.cnt;
  end

endmodule // rlds_top
`default_nettype wire

// >>> testbench/rlds_chk.sv
// Port checker for the receive input select block
`timescale 1ns/1ps
`default_nettype none
module rlds_chk #(
  parameter int unsigned N_PORTS = 4
) (
  // Clock, reset and register port
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  // Decoded stream
  input wire logic [N_PORTS-1:0] rx_data,
  input wire logic [N_PORTS-1:0] rx_valid
);
  logic [4:0] cfg_q;
  logic [4:0] cfg_d;
  logic [1:0] mode;
  // Shadow of port 0 configuration
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr && reg_addr == 8'h00) cfg_d = reg_wdata[4:0];
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cfg_q <= 5'h00;
    else cfg_q <= cfg_d;
  end
  assign mode = !cfg_q[0] ? 2'h0 : cfg_q[2] ? 2'h1 : {1'b1, cfg_q[1]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside a read");
  a_unmapped_zero:
    assert property (reg_rd && reg_addr >= 8'h30 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_readback:
    assert property (reg_wr && reg_addr < 8'h04 ##2 reg_rd &&
      reg_addr == $past(reg_addr, 2) |=>
      reg_rdata == ($past(reg_wdata, 3) & 8'h1f))
    else $error("config readback wrong");
  a_mode_status:
    assert property (reg_rd && reg_addr == 8'h10 |=>
      reg_rdata[1:0] == $past(mode))
    else $error("mode status wrong");
  a_reset_quiet:
    assert property ($rose(rst_b) |-> rx_valid == '0 && reg_rdata == 8'h00)
    else $error("outputs active after reset");
  a_data_held:
    assert property (((rx_data ^ $past(rx_data)) & ~rx_valid) == '0)
    else $error("data changed without valid");
  a_dpll_space:
    assert property (rx_valid[0] && mode == 2'h1 |=> (!rx_valid[0]) [*4])
    else $error("recovered bits too close");
  a_ext_burst:
    assert property ($rose(rx_valid[0]) && mode == 2'h2 |->
      rx_valid[0] [*4] ##1 !rx_valid[0])
    else $error("word not four bits");
  c_dual: cover property (rx_valid[0] && rx_data[0] && mode == 2'h1);
  c_cmi: cover property (rx_valid[0] && mode == 2'h3);
  c_ext: cover property (rx_valid[0] && mode == 2'h2);
endmodule // rlds_chk
`default_nettype wire

// >>> testbench/rlds_far_end.sv
// Line front end model driving analog and digital receive pins
`timescale 1ns/1ps
`default_nettype none
module rlds_far_end (
  // Line pins of all ports
  output var logic [3:0] ana_a,
  output var logic [3:0] ana_b,
  output var logic [3:0] rail_p,
  output var logic [3:0] rail_n,
  output var logic [3:0] opt,
  output var logic [3:0] lclk
);
  initial begin
    ana_a = 4'h0;
    ana_b = 4'h0;
    rail_p = 4'hf;
    rail_n = 4'hf;
    opt = 4'h0;
    lclk = 4'h0;
  end
  // half-duty AMI pulses at E1 rate
  task automatic send_ami(input logic [7:0] b, input logic an);
    logic pos;
    pos = 1'b1;
    #7;
    for (int i = 7; i >= 0; i--) begin
      if (b[i] && an) {ana_a[0], ana_b[0]} = {pos, !pos};
      if (b[i] && !an) {rail_p[0], rail_n[0]} = {!pos, pos};
      if (b[i]) pos = !pos;
      #244;
      {ana_a[0], ana_b[0], rail_p[0], rail_n[0]} = 4'h3;
      #244;
    end
  endtask
  // link clock runs only inside a frame
  task automatic send_ext(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      opt[0] = b[i];
      lclk[0] = 1'b1;
      #62.5;
      lclk[0] = 1'b0;
      #62.5;
    end
    opt[0] = ~opt[0];
  endtask
  // CMI: one alternates level, zero is low then high
  task automatic send_cmi(input logic [7:0] b);
    logic lv;
    lv = 1'b0;
    #7;
    for (int i = 7; i >= 0; i--) begin
      if (b[i]) lv = !lv;
      opt[0] = b[i] ? lv : 1'b0;
      lclk[0] = !lclk[0];
      #244;
      opt[0] = b[i] ? lv : 1'b1;
      lclk[0] = !lclk[0];
      #244;
    end
  endtask
endmodule // rlds_far_end
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the receive input select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  import rlds_pkg::*;
  logic [3:0] ana_a, ana_b, rail_p, rail_n, opt, lclk, rx_data, rx_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       clk, rst_b, reg_wr, reg_rd;
  int         bad_count, compares, ones1;
  logic       q0[$];
  rlds_top u_rlds_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_analog_line_a(ana_a),
    .rx_analog_line_b(ana_b), .rx_positive_rail_in(rail_p),
    .rx_negative_rail_in(rail_n), .rx_optical_data_in(opt),
    .rx_optical_clock_in(lclk), .rx_data(rx_data), .rx_valid(rx_valid));
  rlds_far_end u_far (.ana_a(ana_a), .ana_b(ana_b), .rail_p(rail_p),
    .rail_n(rail_n), .opt(opt), .lclk(lclk));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_valid[0] === 1'b1) q0.push_back(rx_data[0]);
    if (rx_valid[1] === 1'b1 && rx_data[1] === 1'b1) ones1++;
  end
  function automatic logic has(input logic [7:0] p);
    logic [7:0] w;
    has = 1'b0;
    w = 8'h00;
    foreach (q0[i]) begin
      w = {w[6:0], q0[i]};
      if (i >= 7 && w === p) has = 1'b1;
    end
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic set_cfg(input logic [7:0] c, input logic [1:0] m);
    logic [7:0] v;
    wr(8'h00, c);
    rd(8'h10, v);
    `CHK(v[1:0], m)
    repeat (30) @(posedge clk);
    q0.delete();
  endtask
  task automatic t_regs();
    logic [7:0] v;
    for (int p = 0; p < 4; p++) begin
      rd(8'(p), v);
      `CHK(v, 8'h00)
    end
    wr(8'h02, 8'h1f);
    rd(8'h02, v);
    `CHK(v, 8'h1f)
    rd(8'h12, v);
    `CHK(v[1:0], 2'h1)
    rd(8'h10, v);
    `CHK(v[1:0], 2'h0)
    wr(8'h05, 8'hff);
    rd(8'h05, v);
    `CHK(v, 8'h00)
    rd(8'h30, v);
    `CHK(v, 8'h00)
    wr(8'h02, 8'h00);
  endtask
  task automatic t_analog();
    int n;
    n = 0;
    set_cfg(8'h00, 2'h0);
    u_far.send_ami(8'hff, 1'b0);
    repeat (40) @(posedge clk);
    foreach (q0[i]) if (q0[i] !== 1'b0) n++;
    `CHK(n, 0)
    u_far.send_ami(8'hb5, 1'b1);
    repeat (60) @(posedge clk);
    `CHK(has(8'hb5), 1'b1)
  endtask
  task automatic t_dual();
    for (int rc = 2; rc < 4; rc++) begin
      set_cfg(8'h01 | 8'(rc << 1), 2'h1);
      u_far.send_ami(8'hdb, 1'b0);
      repeat (200) @(posedge clk);
      `CHK(has(8'hdb), 1'b1)
    end
  endtask
  task automatic t_cmi();
    set_cfg(8'h0b, 2'h3);
    // Zeros give a falling edge per bit so the DPLL locks first
    u_far.send_cmi(8'h00);
    u_far.send_cmi(8'h4d);
    repeat (60) @(posedge clk);
    `CHK(has(8'h4d), 1'b1)
  endtask
  task automatic t_ext();
    logic [7:0] c0, c1;
    for (int p = 0; p < 2; p++) begin
      set_cfg(8'h01 | 8'(p << 3), 2'h2);
      rd(8'h20, c0);
      u_far.send_ext(p ? 8'h96 : 8'h69);
      repeat (40) @(posedge clk);
      rd(8'h20, c1);
      `CHK(8'(c1 - c0), 8'h08)
      `CHK(q0.size(), 8)
      `CHK(has(8'h96), 1'b1)
    end
    `CHK(ones1, 0)
  endtask
  task automatic results();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {bad_count, compares, ones1} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_analog();
    t_dual();
    t_cmi();
    t_ext();
    results();
  end
  initial begin
    #1000000;
    bad_count++;
    results();
  end
endmodule // testbench
bind rlds_top rlds_chk #(.N_PORTS(N_PORTS)) u_rlds_chk (.clk(clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_data(rx_data), .rx_valid(rx_valid));
`default_nettype wire
